// *** bench/hwwd_core_model.sv ***
// Processor core model issuing halt, clear and interrupt requests
`timescale 1ns/100ps
module hwwd_core_model (
  // Clock
  input  logic       aclk,
  // Requests to the controller
  output logic       halt_exec,
  output logic       wdt_clear_exec,
  output logic [7:0] irq_flag,
  output logic [7:0] irq_enable,
  output logic       stack_full,
  // Wake responses
  input  logic       resume_after_halt,
  input  logic       irq_response
);
  int n_resume = 0;
  int n_irq    = 0;

  // Top flag stays pending from the start
  initial
  begin
    halt_exec      = 1'b0;
    wdt_clear_exec = 1'b0;
    irq_flag       = 8'h80;
    irq_enable     = 8'h00;
    stack_full     = 1'b0;
  end

  task automatic halt();
    @(posedge aclk);
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
  endtask

  task automatic clear_wdt();
    @(posedge aclk);
    wdt_clear_exec <= 1'b1;
    @(posedge aclk);
    wdt_clear_exec <= 1'b0;
  endtask

  task automatic arm(input logic [7:0] en, input logic full);
    @(posedge aclk);
    irq_enable <= en;
    stack_full <= full;
  endtask

  task automatic raise(input int b);
    @(posedge aclk);
    irq_flag[b] <= 1'b1;
  endtask

  always @(posedge aclk)
  begin
    if (resume_after_halt)
      n_resume <= n_resume + 1;
    if (irq_response)
      n_irq <= n_irq + 1;
  end
endmodule // hwwd_core_model

// *** bench/hwwd_ctrl_props.sv ***
// Concurrent checks on the halt, wake and watchdog controller ports
`timescale 1ns/100ps
module hwwd_ctrl_props (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Core instructions
  input logic wdt_clear_exec,
  // Clock gating
  input logic sysclk_run,
  input logic timebase_run,
  input logic cpu_halted,
  // Wake actions and flags
  input logic resume_after_halt,
  input logic irq_response,
  input logic pc_sp_reset,
  input logic full_reset,
  input logic wd_reset,
  input logic power_down_flag,
  input logic wd_timeout_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence halt_entry;
    !cpu_halted ##1 cpu_halted;
  endsequence
  sequence wake_exit;
    cpu_halted ##1 !cpu_halted;
  endsequence

  halt_flags_a: assert property (halt_entry |-> power_down_flag && !wd_timeout_flag)
    else $error("halt entry flags wrong");
  wake_cause_a: assert property (wake_exit |->
    resume_after_halt || irq_response || pc_sp_reset || full_reset)
    else $error("halt left without a wake action");
  run_clocks_a: assert property (!cpu_halted |-> sysclk_run && timebase_run)
    else $error("clock stopped while running");
  clock_order_a: assert property (!timebase_run |-> !sysclk_run)
    else $error("system clock runs without time base");
  irq_wake_a: assert property (irq_response |-> $past(cpu_halted) && !resume_after_halt)
    else $error("interrupt response outside a wake");
  pdf_clear_a: assert property ($fell(power_down_flag) |-> $past(wdt_clear_exec))
    else $error("power-down flag dropped without clear");
  timeout_cause_a: assert property ($rose(wd_timeout_flag) |->
    ##[0:1] (wd_reset || pc_sp_reset))
    else $error("time-out flag set without overflow");
  wd_pulse_a: assert property (wd_reset |=> !wd_reset)
    else $error("watchdog reset longer than one cycle");
endmodule // hwwd_ctrl_props

bind hwwd_ctrl hwwd_ctrl_props hwwd_ctrl_props_inst (.aclk, .aresetn, .wdt_clear_exec,
  .sysclk_run, .timebase_run, .cpu_halted, .resume_after_halt, .irq_response,
  .pc_sp_reset, .full_reset, .wd_reset, .power_down_flag, .wd_timeout_flag);

// *** bench/hwwd_ctrl_tb.sv ***
// Self-checking bench for the halt, wake and watchdog controller
`timescale 1ns/100ps
module hwwd_ctrl_tb;
  logic        aclk       = 1'b0;
  logic        aresetn    = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic        awvalid    = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic [7:0]  araddr     = 8'h00;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic [7:0]  port_a_pin = 8'hff;
  logic        lvr_event  = 1'b0;
  logic        ext_reset_n = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic [31:0] rdata, rd_data;
  logic        halt_exec, wdt_clear_exec, stack_full;
  logic [7:0]  irq_flag, irq_enable;
  logic        sysclk_run, timebase_run, slow_run, cpu_halted;
  logic        resume_after_halt, irq_response, pc_sp_reset, full_reset, wd_reset;
  logic        power_down_flag, wd_timeout_flag;
  logic [31:0] clk_exp [4] = '{32'h0, 32'h1, 32'h2, 32'h6};
  logic [31:0] clk_msk [4] = '{32'h7, 32'h7, 32'h6, 32'h6};
  int          n_fail          = 0;
  int          samples_checked = 0;
  int          nr, ni, cyc;

  always #50 aclk = ~aclk;

  hwwd_ctrl hwwd_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .halt_exec, .wdt_clear_exec,
    .irq_flag, .irq_enable, .stack_full, .port_a_pin, .ext_reset_n,
    .lvr_event, .sysclk_run, .timebase_run, .slow_run, .cpu_halted,
    .resume_after_halt, .irq_response, .pc_sp_reset, .full_reset, .wd_reset,
    .power_down_flag, .wd_timeout_flag);

  hwwd_core_model hwwd_core_model_inst (.aclk, .halt_exec, .wdt_clear_exec,
    .irq_flag, .irq_enable, .stack_full, .resume_after_halt, .irq_response);

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask

  task automatic wait_wdr(input int lim);
    cyc = 0;
    while (wd_reset !== 1'b1 && cyc < lim)
    begin
      @(posedge aclk);
      cyc++;
    end
  endtask

  initial
  begin
    repeat (98000) @(posedge aclk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(hwwd_pkg::ADDR_WDOG, 32'h53);
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h0);
    rdc(hwwd_pkg::ADDR_MODE, 32'h2);
    rd(8'h14);
    chk({30'h0, rd_resp}, {30'h0, hwwd_pkg::RESP_SLVERR});
    wr(8'h14, 8'hff);
    chk({30'h0, wr_resp}, {30'h0, hwwd_pkg::RESP_SLVERR});
    wr(hwwd_pkg::ADDR_FLAGS, 8'hff);
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h88);
    @(posedge aclk);
    lvr_event <= 1'b1;
    @(posedge aclk);
    lvr_event <= 1'b0;
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h8c);
    wr(hwwd_pkg::ADDR_FLAGS, 8'h8b);
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h88);
    wr(hwwd_pkg::ADDR_WAKE, 8'h01);
    // Deep, halt with watchdog, idle off, idle on
    for (int i = 0; i < 4; i++)
    begin
      wr(hwwd_pkg::ADDR_WDOG, i == 0 ? 8'ha8 : 8'h53);
      wr(hwwd_pkg::ADDR_MODE, i < 2 ? 8'h00 : 8'h02);
      wr(hwwd_pkg::ADDR_FLAGS, i == 3 ? 8'h80 : 8'h00);
      hwwd_core_model_inst.arm(8'h80 | ((i == 1 || i == 2) ? 8'(1 << i) : 8'h00), i == 1);
      nr = hwwd_core_model_inst.n_resume;
      ni = hwwd_core_model_inst.n_irq;
      hwwd_core_model_inst.halt();
      repeat (20) @(posedge aclk);
      chk({29'h0, sysclk_run, timebase_run, slow_run} & clk_msk[i], clk_exp[i]);
      chk({29'h0, cpu_halted, power_down_flag, wd_timeout_flag}, 32'h6);
      if (i < 3)
        hwwd_core_model_inst.raise(i);
      else
        port_a_pin[0] <= 1'b0;
      for (int k = 0; k < 40 && cpu_halted; k++)
        @(posedge aclk);
      repeat (2) @(posedge aclk);
      port_a_pin[0] <= 1'b1;
      chk(hwwd_core_model_inst.n_resume - nr, i == 2 ? 0 : 1);
      chk(hwwd_core_model_inst.n_irq - ni, i == 2 ? 1 : 0);
    end
    wr(hwwd_pkg::ADDR_WDOG, 8'h00);
    wait_wdr(2000);
    chk({31'h0, cyc >= 600 && cyc <= 960}, 32'h1);
    rdc(hwwd_pkg::ADDR_WDOG, 32'h53);
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h81);
    wr(hwwd_pkg::ADDR_FLAGS, 8'h80);
    rdc(hwwd_pkg::ADDR_FLAGS, 32'h80);
    wr(hwwd_pkg::ADDR_WDOG, 8'h50);
    hwwd_core_model_inst.clear_wdt();
    wait_wdr(90000);
    chk({31'h0, cyc >= 79550 && cyc <= 79900}, 32'h1);
    @(posedge aclk);
    chk({30'h0, wd_timeout_flag, power_down_flag}, 32'h2);
    // External reset wakes a halted core with a full reset
    hwwd_core_model_inst.halt();
    ext_reset_n <= 1'b0;
    for (int k = 0; k < 10 && full_reset !== 1'b1; k++)
      @(posedge aclk);
    ext_reset_n <= 1'b1;
    chk({30'h0, cpu_halted, full_reset}, 32'h1);
    complete_run();
  end
endmodule // hwwd_ctrl_tb

// *** src/hwwd_ctrl.sv ***
// Halt mode, wake-up and watchdog controller with AXI4-Lite registers
`timescale 1ns/100ps
module hwwd_ctrl (
  // Clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // AXI4-Lite write
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  // AXI4-Lite read
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  // Core instructions and interrupt state
  input  logic        halt_exec,
  input  logic        wdt_clear_exec,
  input  logic [7:0]  irq_flag,
  input  logic [7:0]  irq_enable,
  input  logic        stack_full,
  // Pins and reset sources
  input  logic [7:0]  port_a_pin,
  input  logic        ext_reset_n,
  input  logic        lvr_event,
  // Clock gating
  output logic        sysclk_run,
  output logic        timebase_run,
  output logic        slow_run,
  output logic        cpu_halted,
  // Wake and reset actions
  output logic        resume_after_halt,
  output logic        irq_response,
  output logic        pc_sp_reset,
  output logic        full_reset,
  output logic        wd_reset,
  // Status flags
  output logic        power_down_flag,
  output logic        wd_timeout_flag
);

  // Bus state
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]  aw_addr_q, aw_addr_d, w_byte_q, w_byte_d;
  logic        w_lane_q, w_lane_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_do, wen;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  // Control state
  hwwd_pkg::hwwd_state_e st_q, st_d;
  logic [7:0] wdog_q, wdog_d, wake_en_q, wake_en_d, pre_q, pre_d;
  logic       fsys_q, fsys_d, rsvd_q, rsvd_d, lvflag_q, lvflag_d, ctlflag_q, ctlflag_d;
  logic       idle_sel_q, idle_sel_d, pdn_q, pdn_d, to_q, to_d;
  logic [8:0] div_q, div_d;
  logic [1:0] ill_q, ill_d;
  logic       resume_q, resume_d, irq_resp_q, irq_resp_d;
  logic       pcsp_q, pcsp_d, full_q, full_d, wdr_q, wdr_d;
  logic       tick, wd_en, illegal, cnt_clear, cnt_run, ovf;
  logic       ext_lvl, porta_wake;
  logic [7:0] pa_fall, irq_new;

  // Port A and external reset synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pa
      hwwd_pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (port_a_pin[gi]),
        .level   (),
        .fall    (pa_fall[gi])
      );
    end
  endgenerate

  hwwd_pin_sync u_ext_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_reset_n),
    .level   (ext_lvl),
    .fall    ()
  );

  hwwd_wdt_counter u_wdt (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (tick),
    .run        (cnt_run),
    .clear      (cnt_clear),
    .period_sel (wdog_q[hwwd_pkg::PER_MSB:hwwd_pkg::PER_LSB]),
    .overflow   (ovf)
  );

  // Read data selection
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (araddr)
      hwwd_pkg::ADDR_WDOG:  rd_byte = wdog_q;
      hwwd_pkg::ADDR_FLAGS: rd_byte = {fsys_q, 3'h0, rsvd_q, lvflag_q, 1'b0, ctlflag_q};
      hwwd_pkg::ADDR_MODE:  rd_byte = {6'h00, idle_sel_q, 1'b0};
      hwwd_pkg::ADDR_WAKE:  rd_byte = wake_en_q;
      hwwd_pkg::ADDR_STAT:  rd_byte = {3'h0, st_q, to_q, pdn_q};
      default:              rd_hit  = 1'b0;
    endcase
  end

  assign awready = !aw_hold_q;
  assign wready  = !w_hold_q;
  assign arready = !rvalid_q;
  assign wr_do   = aw_hold_q && w_hold_q && !bvalid_q;
  assign wen     = wr_do && w_lane_q;

  // Bus next state
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (awvalid && !aw_hold_q)
    begin
      aw_hold_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && !w_hold_q)
    begin
      w_hold_d = 1'b1;
      w_byte_d = wdata[7:0];
      w_lane_d = wstrb[0];
    end
    if (wr_do)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = hwwd_pkg::RESP_OKAY;
      if (aw_addr_q != hwwd_pkg::ADDR_WDOG && aw_addr_q != hwwd_pkg::ADDR_FLAGS &&
          aw_addr_q != hwwd_pkg::ADDR_MODE && aw_addr_q != hwwd_pkg::ADDR_WAKE &&
          aw_addr_q != hwwd_pkg::ADDR_STAT)
        bresp_d = hwwd_pkg::RESP_SLVERR;
    end
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rd_byte};
      rresp_d  = rd_hit ? hwwd_pkg::RESP_OKAY : hwwd_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h00000000;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_byte_q  <= w_byte_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Clock gating decode
  assign sysclk_run   = (st_q == hwwd_pkg::ST_RUN) || (st_q == hwwd_pkg::ST_IDLE_ON);
  assign timebase_run = (st_q == hwwd_pkg::ST_RUN) || (st_q == hwwd_pkg::ST_IDLE_OFF) ||
                        (st_q == hwwd_pkg::ST_IDLE_ON);
  assign slow_run     = (st_q != hwwd_pkg::ST_DEEP);
  assign cpu_halted   = (st_q != hwwd_pkg::ST_RUN);

  assign wd_en      = (wdog_q[hwwd_pkg::EN_MSB:hwwd_pkg::EN_LSB] == hwwd_pkg::EN_CODE_ON);
  assign illegal    = !wd_en &&
                      (wdog_q[hwwd_pkg::EN_MSB:hwwd_pkg::EN_LSB] != hwwd_pkg::EN_CODE_OFF);
  assign tick       = slow_run && (div_q == hwwd_pkg::SLOW_DIV_LAST);
  assign cnt_run    = wd_en && slow_run;
  assign porta_wake = |(pa_fall & wake_en_q);
  assign irq_new    = irq_flag & ~pre_q;
  assign cnt_clear  = wdt_clear_exec || illegal || !ext_lvl ||
                      (halt_exec && st_q == hwwd_pkg::ST_RUN);

  // Control next state
  always_comb
  begin
    st_d       = st_q;
    wdog_d     = wdog_q;
    wake_en_d  = wake_en_q;
    pre_d      = pre_q;
    fsys_d     = fsys_q;
    rsvd_d     = rsvd_q;
    lvflag_d   = lvflag_q;
    ctlflag_d  = ctlflag_q;
    idle_sel_d = idle_sel_q;
    pdn_d      = pdn_q;
    to_d       = to_q;
    ill_d      = ill_q;
    div_d      = slow_run ? ((tick) ? 9'h000 : div_q + 9'h001) : div_q;
    resume_d   = 1'b0;
    irq_resp_d = 1'b0;
    pcsp_d     = 1'b0;
    full_d     = 1'b0;
    wdr_d      = 1'b0;

    // Register writes; the bus changes them, as do lvr_event and the illegal-code reset, but halting does not
    if (wen)
    begin
      case (aw_addr_q)
        hwwd_pkg::ADDR_WDOG:  wdog_d    = w_byte_q;
        hwwd_pkg::ADDR_WAKE:  wake_en_d = w_byte_q;
        hwwd_pkg::ADDR_MODE:  idle_sel_d = w_byte_q[hwwd_pkg::IDLE_SEL_BIT];
        hwwd_pkg::ADDR_FLAGS:
        begin
          fsys_d    = w_byte_q[hwwd_pkg::KEEP_ON_BIT];
          rsvd_d    = w_byte_q[hwwd_pkg::RSVD_BIT];
          lvflag_d  = lvflag_q & w_byte_q[hwwd_pkg::LV_FLAG_BIT];
          ctlflag_d = ctlflag_q & w_byte_q[hwwd_pkg::CTL_FLAG_BIT];
        end
        default: ;
      endcase
    end
    if (lvr_event)
      lvflag_d = 1'b1;

    // Illegal enable code: reset after the third slow tick
    if (!illegal)
      ill_d = 2'h0;
    else if (tick)
    begin
      if (ill_q == hwwd_pkg::ILL_TICKS_LAST)
      begin
        ill_d  = 2'h0;
        wdr_d  = 1'b1;
        ctlflag_d = 1'b1;
        wdog_d    = hwwd_pkg::WDOG_RST;
        st_d   = hwwd_pkg::ST_RUN;
      end
      else
        ill_d = ill_q + 2'h1;
    end

    case (st_q)
      hwwd_pkg::ST_RUN:
      begin
        if (wdt_clear_exec)
          pdn_d = 1'b0;
        if (!ext_lvl)
          full_d = 1'b1;
        else if (ovf)
        begin
          wdr_d = 1'b1;
          to_d  = 1'b1;
        end
        else if (halt_exec && !wdr_d)
        begin
          pdn_d = 1'b1;
          to_d  = 1'b0;
          pre_d = irq_flag;
          if (!idle_sel_q)
            st_d = wd_en ? hwwd_pkg::ST_HALT_WD : hwwd_pkg::ST_DEEP;
          else
            st_d = fsys_q ? hwwd_pkg::ST_IDLE_ON : hwwd_pkg::ST_IDLE_OFF;
        end
      end
      hwwd_pkg::ST_DEEP, hwwd_pkg::ST_HALT_WD, hwwd_pkg::ST_IDLE_OFF, hwwd_pkg::ST_IDLE_ON:
      begin
        if (!ext_lvl)
        begin
          full_d = 1'b1;
          st_d   = hwwd_pkg::ST_RUN;
        end
        else if (ovf)
        begin
          to_d   = 1'b1;
          pcsp_d = 1'b1;
          st_d   = hwwd_pkg::ST_RUN;
        end
        else if (porta_wake)
        begin
          resume_d = 1'b1;
          st_d     = hwwd_pkg::ST_RUN;
        end
        else if (|irq_new)
        begin
          if (|(irq_new & irq_enable) && !stack_full)
            irq_resp_d = 1'b1;
          else
            resume_d = 1'b1;
          st_d = hwwd_pkg::ST_RUN;
        end
      end
      default: st_d = hwwd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q       <= hwwd_pkg::ST_RUN;
      wdog_q     <= hwwd_pkg::WDOG_RST;
      wake_en_q  <= hwwd_pkg::WAKE_RST;
      pre_q      <= 8'h00;
      fsys_q     <= hwwd_pkg::FLAGS_RST[hwwd_pkg::KEEP_ON_BIT];
      rsvd_q     <= hwwd_pkg::FLAGS_RST[hwwd_pkg::RSVD_BIT];
      lvflag_q   <= hwwd_pkg::FLAGS_RST[hwwd_pkg::LV_FLAG_BIT];
      ctlflag_q  <= hwwd_pkg::FLAGS_RST[hwwd_pkg::CTL_FLAG_BIT];
      idle_sel_q <= hwwd_pkg::MODE_RST[hwwd_pkg::IDLE_SEL_BIT];
      pdn_q      <= 1'b0;
      to_q       <= 1'b0;
      div_q      <= 9'h000;
      ill_q      <= 2'h0;
      resume_q   <= 1'b0;
      irq_resp_q <= 1'b0;
      pcsp_q     <= 1'b0;
      full_q     <= 1'b0;
      wdr_q      <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      wdog_q     <= wdog_d;
      wake_en_q  <= wake_en_d;
      pre_q      <= pre_d;
      fsys_q     <= fsys_d;
      rsvd_q     <= rsvd_d;
      lvflag_q   <= lvflag_d;
      ctlflag_q  <= ctlflag_d;
      idle_sel_q <= idle_sel_d;
      pdn_q      <= pdn_d;
      to_q       <= to_d;
      div_q      <= div_d;
      ill_q      <= ill_d;
      resume_q   <= resume_d;
      irq_resp_q <= irq_resp_d;
      pcsp_q     <= pcsp_d;
      full_q     <= full_d;
      wdr_q      <= wdr_d;
    end
  end

  assign bvalid            = bvalid_q;
  assign bresp             = bresp_q;
  assign rvalid            = rvalid_q;
  assign rresp             = rresp_q;
  assign rdata             = rdata_q;
  assign resume_after_halt = resume_q;
  assign irq_response      = irq_resp_q;
  assign pc_sp_reset       = pcsp_q;
  assign full_reset        = full_q;
  assign wd_reset          = wdr_q;
  assign power_down_flag   = pdn_q;
  assign wd_timeout_flag   = to_q;

endmodule // hwwd_ctrl

// *** src/hwwd_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/100ps
module hwwd_pin_sync (
  // Clock and reset
  input  logic aclk,
  input  logic aresetn,
  // Pin and results
  input  logic pin,
  output logic level,
  output logic fall
);

  logic s1_q, s2_q, s3_q, lvl_q, fall_q;
  logic s3_d, lvl_d, fall_d;

  always_comb
  begin
    s3_d   = s2_q;
    lvl_d  = lvl_q;
    fall_d = 1'b0;
    if (s2_q == s3_q)
    begin
      lvl_d  = s3_q;
      fall_d = lvl_q & ~s3_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      lvl_q  <= 1'b1;
      fall_q <= 1'b0;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s3_d;
      lvl_q  <= lvl_d;
      fall_q <= fall_d;
    end
  end

  assign level = lvl_q;
  assign fall  = fall_q;

endmodule // hwwd_pin_sync

// *** src/hwwd_pkg.sv ***
// Shared constants and types for the halt, wake and watchdog controller
package hwwd_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_WDOG  = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_MODE  = 8'h08;
  localparam logic [7:0] ADDR_WAKE  = 8'h0c;
  localparam logic [7:0] ADDR_STAT  = 8'h10;

  // Reset values
  localparam logic [7:0] WDOG_RST  = 8'h53;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h02;
  localparam logic [7:0] WAKE_RST  = 8'h00;

  // Field positions
  localparam int EN_MSB        = 7;
  localparam int EN_LSB        = 3;
  localparam int PER_MSB       = 2;
  localparam int PER_LSB       = 0;
  localparam int KEEP_ON_BIT   = 7;
  localparam int RSVD_BIT      = 3;
  localparam int LV_FLAG_BIT   = 2;
  localparam int CTL_FLAG_BIT  = 0;
  localparam int IDLE_SEL_BIT = 1;

  // Enable field codes
  localparam logic [4:0] EN_CODE_OFF = 5'h15;
  localparam logic [4:0] EN_CODE_ON  = 5'h0a;

  // Timing
  localparam int         ACLK_HZ        = 32'h0098_9680;
  localparam int         SLOW_HZ        = 32'h0000_7d00;
  localparam int         SLOW_DIV       = ACLK_HZ / SLOW_HZ;
  localparam logic [8:0] SLOW_DIV_LAST  = 9'(SLOW_DIV - 1);
  localparam logic [1:0] ILL_TICKS_LAST = 2'h2;
  localparam logic [15:0] PERIOD_MIN    = 16'h0100;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_DEEP     = 3'b001,
    ST_HALT_WD  = 3'b010,
    ST_IDLE_OFF = 3'b011,
    ST_IDLE_ON  = 3'b100
  } hwwd_state_e;

endpackage

// *** src/hwwd_wdt_counter.sv ***
// Watchdog counter with power-of-two period select
`timescale 1ns/100ps
module hwwd_wdt_counter (
  // Clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // Control
  input  logic       tick,
  input  logic       run,
  input  logic       clear,
  input  logic [2:0] period_sel,
  // Result
  output logic       overflow
);

  logic [15:0] cnt_q, cnt_d, last;
  logic        ovf_q, ovf_d;

  always_comb
  begin
    last  = (hwwd_pkg::PERIOD_MIN << period_sel) - 16'h0001;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (clear)
      cnt_d = 16'h0000;
    else if (run && tick)
    begin
      if (cnt_q >= last)
      begin
        cnt_d = 16'h0000;
        ovf_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign overflow = ovf_q;

endmodule // hwwd_wdt_counter
